// File: atf_pkg.sv
// Constants, types and register layout of the task file register block
package atf_pkg;

    // Register addresses on A2..A0, task file block
    localparam logic [2:0] ADDR_FEATURE = 3'h1;
    localparam logic [2:0] ADDR_COUNT = 3'h2;
    localparam logic [2:0] ADDR_SECTOR = 3'h3;
    localparam logic [2:0] ADDR_CYL_LOW = 3'h4;
    localparam logic [2:0] ADDR_CYL_HIGH = 3'h5;
    localparam logic [2:0] ADDR_UNIT_HEAD = 3'h6;
    localparam logic [2:0] ADDR_STATUS = 3'h7;
    // Control block addresses (second chip select)
    localparam logic [2:0] ADDR_ALT_STATUS = 3'h6;

    // Unit/head field positions
    localparam int UH_LBA_BIT = 6;
    localparam int UH_UNIT_BIT = 4;
    localparam int UH_HEAD_MSB = 3;
    // Device control field positions
    localparam int DC_SRST_BIT = 2;
    localparam int DC_MASK_BIT = 1;
    // Status byte bit positions
    localparam int ST_BUSY_BIT = 7;
    localparam int ST_READY_BIT = 6;
    localparam int ST_FAULT_BIT = 5;
    localparam int ST_SEEK_BIT = 4;
    localparam int ST_XFER_BIT = 3;
    localparam int ST_CORRECTED_FLAG_BIT = 2;
    localparam int ST_MARK_BIT = 1;
    localparam int ST_ERR_BIT = 0;

    // Reset values and the full 256-sector count
    localparam logic [7:0] COUNT_RESET = 8'h01;
    localparam logic [7:0] ZERO_BYTE = 8'h00;
    localparam logic [7:0] UNIT_HEAD_RESET = 8'ha0;
    localparam logic [8:0] FULL_COUNT = 9'h100;

    // Pin vector: {cs0_n, cs1_n, iord_n, iowr_n, addr[2:0], data[7:0]}
    localparam int PIN_W = 15;
    localparam logic [14:0] PIN_IDLE = 15'h7800;

    // Media command codes and masks
    localparam logic [7:0] OP_SEEK_MASK = 8'hf0;
    localparam logic [7:0] OP_SEEK = 8'h70;

    // Register targets of a host access
    typedef enum logic [3:0] {
        SEL_NONE = 4'h0,
        SEL_FEATURE = 4'h1,
        SEL_COUNT = 4'h2,
        SEL_SECTOR = 4'h3,
        SEL_CYL_LOW = 4'h4,
        SEL_CYL_HIGH = 4'h5,
        SEL_UNIT_HEAD = 4'h6,
        SEL_STATUS = 4'h7,
        SEL_ALT = 4'h8,
        SEL_DEVCTL = 4'h9
    } atf_sel_t;

    // Condition levels reported by the card core
    typedef struct packed {
        logic busy;
        logic ready;
        logic fault;
        logic seek_done;
    } atf_core_state_t;

    // Parameters handed to the core with an accepted command
    typedef struct packed {
        logic [7:0] code;
        logic [7:0] feature;
        logic lba_mode;
        logic [27:0] block_addr;
        logic [15:0] cylinder;
        logic [3:0] head;
        logic [7:0] sector;
        logic [8:0] sectors;
    } atf_cmd_t;

endpackage

// File: atf_task_file.sv
// Task file registers, status byte and interrupt request of the card
`timescale 1ns/10ps
`default_nettype none
module atf_task_file
    import atf_pkg::*;
(
    input wire logic clock_i,
    input wire logic resetn_i,
    input wire logic ce_i,
    // Host pins
    input wire logic host_cs0_n_i,
    input wire logic host_cs1_n_i,
    input wire logic host_iord_n_i,
    input wire logic host_iowr_n_i,
    input wire logic [2:0] host_addr_i,
    input wire logic [7:0] host_data_i,
    output logic [7:0] host_data_o,
    output logic host_data_oe_o,
    output logic card_interrupt_request_n_o,
    // Card configuration, same clock
    input wire logic unit_number_i,
    input wire logic io_card_mode_i,
    input wire logic level_irq_mode_i,
    // Card core side
    input wire atf_core_state_t core_state_i,
    input wire logic core_xfer_set_i,
    input wire logic core_xfer_clear_i,
    input wire logic core_corrected_i,
    input wire logic core_error_i,
    input wire logic core_sector_done_i,
    input wire logic core_cmd_done_i,
    output atf_cmd_t cmd_o,
    output logic cmd_strobe_o,
    output logic cmd_refused_o,
    output logic soft_reset_o
);

    // Map chip selects and address to a register target
    function automatic atf_sel_t decode_sel(input logic cs0_n, input logic cs1_n, input logic [2:0] addr);
        atf_sel_t sel;
        sel = SEL_NONE;
        if (!cs0_n && cs1_n) begin
            case (addr)
                ADDR_FEATURE: sel = SEL_FEATURE;
                ADDR_COUNT: sel = SEL_COUNT;
                ADDR_SECTOR: sel = SEL_SECTOR;
                ADDR_CYL_LOW: sel = SEL_CYL_LOW;
                ADDR_CYL_HIGH: sel = SEL_CYL_HIGH;
                ADDR_UNIT_HEAD: sel = SEL_UNIT_HEAD;
                ADDR_STATUS: sel = SEL_STATUS;
                default: sel = SEL_NONE;
            endcase
        end else if (cs0_n && !cs1_n && addr == ADDR_ALT_STATUS) begin
            sel = SEL_ALT;
        end
        return sel;
    endfunction

    // Read, write and seek commands that need the media ready
    function automatic logic is_media_cmd(input logic [7:0] code);
        logic hit;
        hit = 1'b0;
        case (code)
            8'h20, 8'h21, 8'h22, 8'h23, 8'h30, 8'h31, 8'h32, 8'h33, 8'h38, 8'h3c,
            8'h40, 8'h41, 8'hc4, 8'hc5, 8'hcd: hit = 1'b1;
            default: hit = ((code & OP_SEEK_MASK) == OP_SEEK);
        endcase
        return hit;
    endfunction

    logic [PIN_W-1:0] pin_meta_reg;
    logic [PIN_W-1:0] pin_sync_reg;
    logic iord_prev_reg;
    logic iowr_prev_reg;
    logic wr_cs0_n_reg;
    logic wr_cs1_n_reg;
    logic [2:0] wr_addr_reg;
    logic [7:0] wr_data_reg;
    logic [7:0] feature_select_reg;
    logic [7:0] transfer_sector_count_reg;
    logic [7:0] start_sector_number_reg;
    logic [7:0] start_cylinder_low_reg;
    logic [7:0] start_cylinder_high_reg;
    logic [7:0] unit_and_head_select_reg;
    logic interrupt_mask_bit_reg;
    logic srst_reg;
    logic transfer_request_flag_reg;
    logic corrected_flag_reg;
    logic error_flag_reg;
    logic irq_pending_reg;
    logic irq_n_reg;
    logic [7:0] rd_data_reg;
    logic rd_oe_reg;
    logic strobe_reg;
    logic refused_reg;
    atf_cmd_t cmd_reg;

    logic s_cs0_n;
    logic s_cs1_n;
    logic s_iord_n;
    logic s_iowr_n;
    logic [2:0] s_addr;
    logic [7:0] s_data;
    logic rd_start;
    logic wr_end;
    atf_sel_t rd_sel;
    atf_sel_t wr_sel;
    atf_sel_t ctl_sel;
    logic unit_match;
    logic cmd_write;
    logic cmd_take;
    logic cmd_refuse;
    logic tf_write;
    logic status_clear;
    logic [7:0] card_status;
    logic [8:0] sectors_next;

    // Two-flop synchroniser on every host pin
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pin_meta_reg <= PIN_IDLE;
            pin_sync_reg <= PIN_IDLE;
        end else if (ce_i) begin
            pin_meta_reg <= {host_cs0_n_i, host_cs1_n_i, host_iord_n_i, host_iowr_n_i, host_addr_i, host_data_i};
            pin_sync_reg <= pin_meta_reg;
        end
    end

    assign {s_cs0_n, s_cs1_n, s_iord_n, s_iowr_n, s_addr, s_data} = pin_sync_reg;

    // Strobe edges on the synchronised copies
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            iord_prev_reg <= 1'b1;
            iowr_prev_reg <= 1'b1;
        end else if (ce_i) begin
            iord_prev_reg <= s_iord_n;
            iowr_prev_reg <= s_iowr_n;
        end
    end

    assign rd_start = iord_prev_reg && !s_iord_n;
    assign wr_end = !iowr_prev_reg && s_iowr_n;

    // Hold address and data while the write strobe is low; commit at its end,
    // when data has had the whole strobe to settle
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            wr_cs0_n_reg <= 1'b1;
            wr_cs1_n_reg <= 1'b1;
            wr_addr_reg <= 3'h0;
            wr_data_reg <= ZERO_BYTE;
        end else if (ce_i && !s_iowr_n) begin
            wr_cs0_n_reg <= s_cs0_n;
            wr_cs1_n_reg <= s_cs1_n;
            wr_addr_reg <= s_addr;
            wr_data_reg <= s_data;
        end
    end

    // Decode of the held write and the live read
    always_comb begin
        wr_sel = decode_sel(wr_cs0_n_reg, wr_cs1_n_reg, wr_addr_reg);
        rd_sel = decode_sel(s_cs0_n, s_cs1_n, s_addr);
        ctl_sel = (wr_cs0_n_reg && !wr_cs1_n_reg && wr_addr_reg == ADDR_ALT_STATUS) ? SEL_DEVCTL : SEL_NONE;
    end

    // Command acceptance; the host loads parameters first
    assign unit_match = (unit_and_head_select_reg[UH_UNIT_BIT] == unit_number_i);
    assign cmd_write = wr_end && wr_sel == SEL_STATUS && unit_match && !core_state_i.busy && !srst_reg;
    assign cmd_refuse = cmd_write && is_media_cmd(wr_data_reg)
        && !(core_state_i.ready && core_state_i.seek_done);
    assign cmd_take = cmd_write && !cmd_refuse;
    // Parameter writes are ignored while the core is busy
    assign tf_write = wr_end && !core_state_i.busy && !srst_reg;
    assign status_clear = rd_start && rd_sel == SEL_STATUS && io_card_mode_i && level_irq_mode_i;

    // Status byte, shared by both status addresses
    always_comb begin
        card_status = ZERO_BYTE;
        card_status[ST_BUSY_BIT] = core_state_i.busy;
        card_status[ST_READY_BIT] = core_state_i.ready;
        card_status[ST_FAULT_BIT] = core_state_i.fault;
        card_status[ST_SEEK_BIT] = core_state_i.seek_done;
        card_status[ST_XFER_BIT] = transfer_request_flag_reg;
        card_status[ST_CORRECTED_FLAG_BIT] = corrected_flag_reg;
        card_status[ST_MARK_BIT] = 1'b0;
        card_status[ST_ERR_BIT] = error_flag_reg;
    end

    // Feature byte, never read back
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            feature_select_reg <= ZERO_BYTE;
        end else if (ce_i) begin
            if (srst_reg) begin
                feature_select_reg <= ZERO_BYTE;
            end else if (tf_write && wr_sel == SEL_FEATURE) begin
                feature_select_reg <= wr_data_reg;
            end
        end
    end

    // Sector count: host load, counts down per finished sector so a broken
    // transfer leaves what is still owed
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            transfer_sector_count_reg <= COUNT_RESET;
        end else if (ce_i) begin
            if (srst_reg) begin
                transfer_sector_count_reg <= COUNT_RESET;
            end else if (tf_write && wr_sel == SEL_COUNT) begin
                transfer_sector_count_reg <= wr_data_reg;
            end else if (core_sector_done_i) begin
                transfer_sector_count_reg <= transfer_sector_count_reg - 8'h01;
            end
        end
    end

    // Address registers of the next transfer
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            start_sector_number_reg <= ZERO_BYTE;
            start_cylinder_low_reg <= ZERO_BYTE;
            start_cylinder_high_reg <= ZERO_BYTE;
            unit_and_head_select_reg <= UNIT_HEAD_RESET;
        end else if (ce_i) begin
            if (srst_reg) begin
                start_sector_number_reg <= ZERO_BYTE;
                start_cylinder_low_reg <= ZERO_BYTE;
                start_cylinder_high_reg <= ZERO_BYTE;
                unit_and_head_select_reg <= UNIT_HEAD_RESET;
            end else if (tf_write) begin
                case (wr_sel)
                    SEL_SECTOR: start_sector_number_reg <= wr_data_reg;
                    SEL_CYL_LOW: start_cylinder_low_reg <= wr_data_reg;
                    SEL_CYL_HIGH: start_cylinder_high_reg <= wr_data_reg;
                    SEL_UNIT_HEAD: unit_and_head_select_reg <= wr_data_reg;
                    default: ;
                endcase
            end
        end
    end

    // Device control: mask and soft reset, accepted even while busy
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            interrupt_mask_bit_reg <= 1'b0;
            srst_reg <= 1'b0;
        end else if (ce_i && wr_end && ctl_sel == SEL_DEVCTL) begin
            interrupt_mask_bit_reg <= wr_data_reg[DC_MASK_BIT];
            srst_reg <= wr_data_reg[DC_SRST_BIT];
        end
    end

    // Sticky status flags: a core set wins over the clear of a new command
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            transfer_request_flag_reg <= 1'b0;
            corrected_flag_reg <= 1'b0;
            error_flag_reg <= 1'b0;
        end else if (ce_i) begin
            if (core_xfer_set_i) begin
                transfer_request_flag_reg <= 1'b1;
            end else if (cmd_write || core_xfer_clear_i || srst_reg) begin
                transfer_request_flag_reg <= 1'b0;
            end
            if (core_corrected_i) begin
                corrected_flag_reg <= 1'b1;
            end else if (cmd_write || srst_reg) begin
                corrected_flag_reg <= 1'b0;
            end
            if (core_error_i || cmd_refuse) begin
                error_flag_reg <= 1'b1;
            end else if (cmd_take || srst_reg) begin
                error_flag_reg <= 1'b0;
            end
        end
    end

    // Interrupt request; a primary status read in I/O level mode or a soft reset drops it, and a
    // completion in the same cycle keeps it up
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            irq_pending_reg <= 1'b0;
            irq_n_reg <= 1'b1;
        end else if (ce_i) begin
            if (core_cmd_done_i) begin
                irq_pending_reg <= 1'b1;
            end else if (status_clear || srst_reg) begin
                irq_pending_reg <= 1'b0;
            end
            irq_n_reg <= !(irq_pending_reg && !interrupt_mask_bit_reg);
        end
    end

    // Read data: loaded at the strobe's fall, driven while it stays low
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rd_data_reg <= ZERO_BYTE;
            rd_oe_reg <= 1'b0;
        end else if (ce_i) begin
            if (rd_start) begin
                case (rd_sel)
                    SEL_COUNT: rd_data_reg <= transfer_sector_count_reg;
                    SEL_SECTOR: rd_data_reg <= start_sector_number_reg;
                    SEL_CYL_LOW: rd_data_reg <= start_cylinder_low_reg;
                    SEL_CYL_HIGH: rd_data_reg <= start_cylinder_high_reg;
                    SEL_UNIT_HEAD: rd_data_reg <= unit_and_head_select_reg;
                    SEL_STATUS, SEL_ALT: rd_data_reg <= card_status;
                    default: rd_data_reg <= ZERO_BYTE;
                endcase
                rd_oe_reg <= (rd_sel != SEL_NONE && rd_sel != SEL_FEATURE);
            end else if (s_iord_n) begin
                rd_oe_reg <= 1'b0;
            end
        end
    end

    // Zero count stands for a full 256-sector request
    assign sectors_next = (transfer_sector_count_reg == ZERO_BYTE) ? FULL_COUNT
        : {1'b0, transfer_sector_count_reg};

    // Parameter snapshot handed to the core with each accepted command
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cmd_reg <= '0;
            strobe_reg <= 1'b0;
            refused_reg <= 1'b0;
        end else if (ce_i) begin
            strobe_reg <= cmd_take;
            refused_reg <= cmd_refuse;
            if (cmd_take) begin
                cmd_reg.code <= wr_data_reg;
                cmd_reg.feature <= feature_select_reg;
                cmd_reg.lba_mode <= unit_and_head_select_reg[UH_LBA_BIT];
                cmd_reg.block_addr <= {unit_and_head_select_reg[UH_HEAD_MSB:0], start_cylinder_high_reg,
                    start_cylinder_low_reg, start_sector_number_reg};
                cmd_reg.cylinder <= {start_cylinder_high_reg, start_cylinder_low_reg};
                cmd_reg.head <= unit_and_head_select_reg[UH_HEAD_MSB:0];
                cmd_reg.sector <= start_sector_number_reg;
                cmd_reg.sectors <= sectors_next;
            end
        end
    end

    assign host_data_o = rd_data_reg;
    assign host_data_oe_o = rd_oe_reg;
    assign card_interrupt_request_n_o = irq_n_reg;
    assign cmd_o = cmd_reg;
    assign cmd_strobe_o = strobe_reg;
    assign cmd_refused_o = refused_reg;
    assign soft_reset_o = srst_reg;

    // Checks on the block's own behaviour
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!resetn_i);

    a_zero_count_full: assert property (ce_i && cmd_take && transfer_sector_count_reg == ZERO_BYTE |=>
        cmd_o.sectors == FULL_COUNT) else $error("zero count not taken as 256");
    a_count_decrement: assert property (ce_i && core_sector_done_i && !srst_reg
        && !(tf_write && wr_sel == SEL_COUNT)
        |=> transfer_sector_count_reg == $past(transfer_sector_count_reg) - 8'h01)
        else $error("sector count not decremented");
    a_lba_address: assert property (ce_i && cmd_take |=>
        cmd_o.block_addr == {$past(unit_and_head_select_reg[UH_HEAD_MSB:0]), $past(start_cylinder_high_reg),
        $past(start_cylinder_low_reg), $past(start_sector_number_reg)}) else $error("block address badly formed");
    a_foreign_unit: assert property (ce_i && wr_end && wr_sel == SEL_STATUS && !unit_match |=>
        !cmd_strobe_o && !cmd_refused_o) else $error("command taken for other unit");
    a_status_irq_drop: assert property (ce_i && status_clear && !core_cmd_done_i ##1 ce_i |=>
        card_interrupt_request_n_o) else $error("status read kept interrupt");
    a_not_ready_refuse: assert property (ce_i && cmd_write && is_media_cmd(wr_data_reg)
        && !core_state_i.ready |=> cmd_refused_o && !cmd_strobe_o ##1 1'b1)
        else $error("media command taken while not ready");
    a_marker_zero: assert property (rd_oe_reg && $past(rd_sel) == SEL_STATUS && $past(rd_start) |->
        !host_data_o[ST_MARK_BIT]) else $error("rotation marker bit set");
    a_error_cleared: assert property (ce_i && cmd_take && !core_error_i |=> !error_flag_reg [*2] or
        (!error_flag_reg ##1 1'b1)) else $error("next command left error flag");
    a_alt_keeps_irq: assert property (ce_i && rd_start && rd_sel == SEL_ALT && irq_pending_reg
        && !srst_reg |=> irq_pending_reg) else $error("alternate read dropped interrupt");
    a_mask_blocks: assert property (ce_i && interrupt_mask_bit_reg && $past(interrupt_mask_bit_reg) |=>
        card_interrupt_request_n_o) else $error("masked interrupt asserted");

    c_cmd_taken: cover property (cmd_strobe_o && cmd_o.lba_mode);
    c_cmd_refused: cover property (cmd_refused_o);
    c_status_clear: cover property (irq_pending_reg ##1 status_clear ##2 card_interrupt_request_n_o);
    c_partial: cover property (core_sector_done_i && transfer_sector_count_reg != 8'h01);

endmodule // atf_task_file
`default_nettype wire

// File: atf_host_model.sv
// Host side model driving the task file pins
`timescale 1ns/10ps
`default_nettype none
module atf_host_model (
    input wire logic clock_i,
    input wire logic [8:0] rd_i,
    output logic cs0_n_o,
    output logic cs1_n_o,
    output logic iord_n_o,
    output logic iowr_n_o,
    output logic [2:0] addr_o,
    output logic [7:0] data_o
);
    // Idle pins at time zero
    initial begin
        cs0_n_o = 1'b1;
        cs1_n_o = 1'b1;
        iord_n_o = 1'b1;
        iowr_n_o = 1'b1;
        addr_o = 3'h0;
        data_o = 8'h00;
    end
    // One byte access; long strobes cover the two-edge pin sync
    task automatic acc(input logic cs1, input logic wr, input logic [2:0] a, input logic [7:0] d,
        output logic [8:0] q);
        @(posedge clock_i);
        cs0_n_o <= cs1;
        cs1_n_o <= !cs1;
        addr_o <= a;
        data_o <= d;
        iowr_n_o <= !wr;
        iord_n_o <= wr;
        repeat (5) @(posedge clock_i);
        q = rd_i;
        iowr_n_o <= 1'b1;
        iord_n_o <= 1'b1;
        @(posedge clock_i);
        cs0_n_o <= 1'b1;
        cs1_n_o <= 1'b1;
        data_o <= ~d; // Released bus never shows the old byte
        repeat (5) @(posedge clock_i);
    endtask
endmodule // atf_host_model
`default_nettype wire

// File: test_ata_task_file_registers.sv
// Self-checking bench of the task file registers
`timescale 1ns/10ps
`default_nettype none
module test_ata_task_file_registers;
    import atf_pkg::*;
    logic clock_i = 1'b0;
    logic resetn_i = 1'b0;
    atf_core_state_t core_state = 4'h0;
    logic [5:0] ev = 6'h00;
    logic io_mode = 1'b0;
    logic ce = 1'b1;
    logic unit = 1'b0;
    logic cs0_n, cs1_n, iord_n, iowr_n, oe, irq_n, strobe, refused, soft_rst;
    logic [2:0] addr;
    logic [7:0] dout, din, s, cl, ch, f;
    logic [3:0] hd;
    atf_cmd_t cmd, got;
    atf_cmd_t exp_q[$];
    int mismatches = 0, checks_done = 0, n_acc = 0, n_ref = 0, cnt = 0;
    always #50 clock_i = ~clock_i;
    atf_host_model atf_host_model_i (.clock_i(clock_i), .rd_i({oe, dout}), .cs0_n_o(cs0_n),
        .cs1_n_o(cs1_n), .iord_n_o(iord_n), .iowr_n_o(iowr_n), .addr_o(addr), .data_o(din));
    atf_task_file atf_task_file_i (.clock_i(clock_i), .resetn_i(resetn_i), .ce_i(ce),
        .host_cs0_n_i(cs0_n), .host_cs1_n_i(cs1_n), .host_iord_n_i(iord_n), .host_iowr_n_i(iowr_n),
        .host_addr_i(addr), .host_data_i(din), .host_data_o(dout), .host_data_oe_o(oe),
        .card_interrupt_request_n_o(irq_n), .unit_number_i(unit), .io_card_mode_i(io_mode),
        .level_irq_mode_i(io_mode), .core_state_i(core_state), .core_xfer_set_i(ev[0]),
        .core_xfer_clear_i(ev[1]), .core_corrected_i(ev[2]), .core_error_i(ev[3]),
        .core_sector_done_i(ev[4]), .core_cmd_done_i(ev[5]), .cmd_o(cmd), .cmd_strobe_o(strobe),
        .cmd_refused_o(refused), .soft_reset_o(soft_rst));
    // Strobes stand one cycle, so count them at every edge
    always @(posedge clock_i) begin
        if (strobe === 1'b1) begin
            n_acc++;
            got = cmd;
            // Every accepted command must match the next modelled one
            if (exp_q.size() == 0)
                chkc(cmd, ~cmd);
            else
                chkc(cmd, exp_q.pop_front());
        end
        if (refused === 1'b1)
            n_ref++;
    end
    task automatic chkb(input logic [8:0] g, input logic [8:0] e);
        checks_done++;
        if (g !== e) begin
            mismatches++;
            $display("BAD %0t value %h expected %h", $time, g, e);
        end
    endtask
    task automatic chkc(input atf_cmd_t g, input atf_cmd_t e);
        checks_done++;
        if (g !== e) begin
            mismatches++;
            $display("BAD %0t command %h expected %h", $time, g, e);
        end
    endtask
    task automatic wr(input logic cs1, input logic [2:0] a, input logic [7:0] d);
        logic [8:0] q;
        atf_host_model_i.acc(cs1, 1'b1, a, d, q);
    endtask
    // Undriven read data is not compared, only the enable
    task automatic rdc(input logic [2:0] a, input logic [8:0] e);
        logic [8:0] q;
        atf_host_model_i.acc(1'b0, 1'b0, a, 8'h00, q);
        chkb(e[8] ? q : {q[8], 8'h00}, e);
    endtask
    // Expected status built after the read, from levels and flag model
    task automatic sts(input logic cs1, input int fl);
        logic [8:0] q;
        atf_host_model_i.acc(cs1, 1'b0, cs1 ? ADDR_ALT_STATUS : ADDR_STATUS, 8'h00, q);
        chkb(q, {1'b1, core_state, 4'(fl)});
    endtask
    task automatic pulse(input int k);
        ev <= 6'h01 << k;
        @(posedge clock_i);
        ev <= 6'h00;
        repeat (3) @(posedge clock_i);
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        void'($urandom(32'h236a4e17));
        repeat (20) @(posedge clock_i);
        resetn_i <= 1'b1;
        rdc(ADDR_COUNT, {1'b1, COUNT_RESET});
        core_state <= 4'h5;
        sts(1'b0, 0);
        s = 8'($urandom);
        cl = 8'($urandom);
        ch = 8'($urandom);
        hd = 4'($urandom);
        f = 8'($urandom);
        wr(1'b0, ADDR_FEATURE, f);
        rdc(ADDR_FEATURE, 9'h000);
        wr(1'b0, ADDR_COUNT, 8'h00);
        wr(1'b0, ADDR_SECTOR, s);
        wr(1'b0, ADDR_CYL_LOW, cl);
        wr(1'b0, ADDR_CYL_HIGH, ch);
        wr(1'b0, ADDR_UNIT_HEAD, {4'he, hd});
        rdc(ADDR_SECTOR, {1'b1, s});
        rdc(ADDR_CYL_LOW, {1'b1, cl});
        rdc(ADDR_CYL_HIGH, {1'b1, ch});
        rdc(ADDR_UNIT_HEAD, {1'b1, 4'he, hd});
        exp_q.push_back(atf_cmd_t'{8'h20, f, 1'b1, {hd, ch, cl, s}, {ch, cl}, hd, s, FULL_COUNT});
        wr(1'b0, ADDR_STATUS, 8'h20);
        chkc(got, '{8'h20, f, 1'b1, {hd, ch, cl, s}, {ch, cl}, hd, s, FULL_COUNT});
        pulse(4);
        pulse(4);
        cnt = (cnt + 254) % 256;
        rdc(ADDR_COUNT, {1'b1, 8'(cnt)});
        pulse(0);
        pulse(2);
        pulse(3);
        sts(1'b0, 'hd);
        sts(1'b1, 'hd);
        wr(1'b0, ADDR_UNIT_HEAD, 8'hb0);
        wr(1'b0, ADDR_STATUS, 8'h20);
        chkb(9'(n_acc), 9'h001);
        wr(1'b0, ADDR_UNIT_HEAD, 8'ha0);
        exp_q.push_back(atf_cmd_t'{8'h20, f, 1'b0, {4'h0, ch, cl, s}, {ch, cl}, 4'h0, s, 9'(cnt)});
        wr(1'b0, ADDR_STATUS, 8'h20);
        sts(1'b0, 0);
        core_state <= 4'h1;
        wr(1'b0, ADDR_STATUS, 8'h30);
        chkb(9'(n_ref), 9'h001);
        sts(1'b0, 1);
        core_state <= 4'h5;
        exp_q.push_back(atf_cmd_t'{8'h40, f, 1'b0, {4'h0, ch, cl, s}, {ch, cl}, 4'h0, s, 9'(cnt)});
        wr(1'b0, ADDR_STATUS, 8'h40);
        sts(1'b0, 0);
        core_state <= 4'hf;
        sts(1'b0, 0);
        core_state <= 4'h5;
        io_mode <= 1'b1;
        pulse(5);
        chkb({8'h00, irq_n}, 9'h000);
        sts(1'b1, 0);
        chkb({8'h00, irq_n}, 9'h000);
        sts(1'b0, 0);
        chkb({8'h00, irq_n}, 9'h001);
        wr(1'b1, ADDR_ALT_STATUS, 8'h0a);
        pulse(5);
        chkb({8'h00, irq_n}, 9'h001);
        // Soft reset held, then released: task file back at reset values
        wr(1'b1, ADDR_ALT_STATUS, 8'h0e);
        chkb({8'h00, soft_rst}, 9'h001);
        wr(1'b1, ADDR_ALT_STATUS, 8'h0a);
        chkb({8'h00, soft_rst}, 9'h000);
        rdc(ADDR_COUNT, {1'b1, COUNT_RESET});
        // Frozen clock enable must not count the sector
        ce <= 1'b0;
        pulse(4);
        ce <= 1'b1;
        rdc(ADDR_COUNT, {1'b1, COUNT_RESET});
        // Second unit number: commands follow the configured unit
        unit <= 1'b1;
        wr(1'b0, ADDR_UNIT_HEAD, 8'hb0);
        exp_q.push_back(atf_cmd_t'{8'h20, 8'h00, 1'b0, 28'h0000000, 16'h0000, 4'h0, 8'h00, 9'h001});
        wr(1'b0, ADDR_STATUS, 8'h20);
        chkb(9'(n_acc), 9'h004);
        chkb(9'(exp_q.size()), 9'h000);
        final_report();
    end
    // Watchdog against a hung sequence
    initial begin
        repeat (5000) @(posedge clock_i);
        mismatches++;
        final_report();
    end
endmodule // test_ata_task_file_registers
`default_nettype wire
